//--- hw/lmt_pkg.sv
// Shared types and constants for the LCD multiplex timing core
package lmt_pkg;

  // ----------------------------------------------------------------
  // Geometry and timing
  // ----------------------------------------------------------------
  localparam int unsigned NUM_SEG          = 32;
  localparam int unsigned NUM_BP           = 4;
  localparam int unsigned FRAME_DIV        = 24;
  localparam int unsigned HALF_FRAME_TICKS = FRAME_DIV / 2;
  localparam int unsigned PHASE_CNT_W      = 4;
  localparam logic [1:0]  ROW_FIRST        = 2'h0;
  localparam logic [1:0]  ROW_SECOND       = 2'h1;
  localparam logic        OSC_SEL_INTERNAL = 1'h0;
  localparam logic        POL_POSITIVE     = 1'h0;

  // ----------------------------------------------------------------
  // Drive configuration
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LMT_DRIVE_STATIC,
    LMT_DRIVE_MUX2,
    LMT_DRIVE_MUX3,
    LMT_DRIVE_MUX4
  } lmt_drive_t;

  typedef enum logic [1:0] {
    LMT_BIAS_STATIC,
    LMT_BIAS_HALF,
    LMT_BIAS_THIRD
  } lmt_bias_t;

  // Output level codes handed to the analog selector
  typedef enum logic [2:0] {
    LMT_LVL_VSS,
    LMT_LVL_THIRD,
    LMT_LVL_HALF,
    LMT_LVL_TWO_THIRDS,
    LMT_LVL_LCD
  } lmt_level_t;

  typedef struct packed {
    lmt_drive_t drive;
    lmt_bias_t  bias;
    logic       enable;
  } lmt_mode_t;

  localparam lmt_mode_t MODE_RESET = '{drive: LMT_DRIVE_MUX4, bias: LMT_BIAS_THIRD, enable: 1'h0};

endpackage : lmt_pkg

//--- hw/lmt_timing.sv
// LCD multiplex timing, display latch and level selection core
`timescale 1ns/1ps

// Notes on behaviour
// - With the source select low, ticks of the internal oscillator time all logic and drive.
// - With the source select high, rising edges of the clock pin are used instead.
// - One frame spans twenty-four ticks of the selected clock.
// - Multiplexing follows the drive configuration loaded by the mode-set strobe.
// - Static mode drives all four backplanes alike with two levels and static bias.
// - 1:2 mode runs with half bias on three levels or third bias on four levels.
// - 1:3 and 1:4 modes also accept half bias.
// - The timing unit fetches display rows from memory and moves them to the segments.
// - The latch holds its row unchanged for the whole backplane phase it serves.
// - Latch bit n drives segment n and comes from memory column n.
// - Reset selects 1:4 with third bias, display off, every output at the LCD supply level.
// - Rows are presented 0,1,2,3 in 1:4, 0 to 2 in 1:3, 0 and 1 in 1:2, and 0 in static.
module lmt_timing
  import lmt_pkg::*;
(
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic                    oscillator_source_select,
  input  wire logic                    int_osc_tick,
  input  wire logic                    ext_clk,
  input  wire logic                    mode_load,
  input  wire lmt_mode_t               mode_cfg,
  input  wire logic [NUM_SEG-1:0]      ram_row_data,
  output lmt_level_t [NUM_BP-1:0]      backplane_outputs,
  output lmt_level_t [NUM_SEG-1:0]     segment_outputs,
  output logic [1:0]                   ram_row_sel,
  output logic                         frame_pulse,
  output lmt_mode_t                    mode_active
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] last_row(input lmt_drive_t d);
    case (d)
      LMT_DRIVE_STATIC: last_row = 2'h0;
      LMT_DRIVE_MUX2:   last_row = 2'h1;
      LMT_DRIVE_MUX3:   last_row = 2'h2;
      default:          last_row = 2'h3;
    endcase
  endfunction : last_row

  // Twelve ticks per frame half split evenly over the rows
  function automatic logic [PHASE_CNT_W-1:0] phase_len(input lmt_drive_t d);
    logic [PHASE_CNT_W-1:0] rows;
    rows      = PHASE_CNT_W'({2'h0, last_row(d)}) + PHASE_CNT_W'(1);
    phase_len = PHASE_CNT_W'(HALF_FRAME_TICKS) / rows;
  endfunction : phase_len

  // Backplane pin to row it carries; 1:3 repeats row 1 on the last pin
  function automatic logic [1:0] bp_row(input lmt_drive_t d, input int unsigned pin);
    logic [1:0] p;
    p = 2'(pin);
    case (d)
      LMT_DRIVE_STATIC: bp_row = ROW_FIRST;
      LMT_DRIVE_MUX2:   bp_row = {1'h0, p[0]};
      LMT_DRIVE_MUX3:   bp_row = (p == 2'h3) ? ROW_SECOND : p;
      default:          bp_row = p;
    endcase
  endfunction : bp_row

  // Whole pin-to-row table for one drive mode
  function automatic logic [NUM_BP-1:0][1:0] bp_rows(input lmt_drive_t d);
    logic [NUM_BP-1:0][1:0] t;
    for (int unsigned i = 0; i < NUM_BP; i++) begin
      t[i] = bp_row(d, i);
    end
    bp_rows = t;
  endfunction : bp_rows

  function automatic lmt_level_t bp_level(input lmt_mode_t m, input logic active, input logic pol);
    lmt_level_t lvl;
    lvl = (pol == POL_POSITIVE) ? LMT_LVL_LCD : LMT_LVL_VSS;
    if (!active) begin
      if (m.bias == LMT_BIAS_HALF) begin
        lvl = LMT_LVL_HALF;
      end else if (m.bias == LMT_BIAS_THIRD) begin
        lvl = (pol == POL_POSITIVE) ? LMT_LVL_THIRD : LMT_LVL_TWO_THIRDS;
      end
    end
    bp_level = lvl;
  endfunction : bp_level

  function automatic lmt_level_t seg_level(input lmt_mode_t m, input logic on, input logic pol);
    lmt_level_t lvl;
    if (on) begin
      lvl = (pol == POL_POSITIVE) ? LMT_LVL_VSS : LMT_LVL_LCD;
    end else if (m.bias == LMT_BIAS_THIRD) begin
      lvl = (pol == POL_POSITIVE) ? LMT_LVL_TWO_THIRDS : LMT_LVL_THIRD;
    end else begin
      lvl = (pol == POL_POSITIVE) ? LMT_LVL_LCD : LMT_LVL_VSS;
    end
    seg_level = lvl;
  endfunction : seg_level

  // ----------------------------------------------------------------
  // Clock source selection
  // ----------------------------------------------------------------
  logic ext_clk_reg;
  logic tick;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ext_clk_reg <= 1'h0;
    end else begin
      ext_clk_reg <= ext_clk;
    end
  end

  // No tick means nothing advances, which is the frozen drive a stopped clock gives
  always_comb begin
    if (oscillator_source_select == OSC_SEL_INTERNAL) begin
      tick = int_osc_tick;
    end else begin
      // Edge detection uses the live pin against its registered copy, so the external source adds no mclk of latency
      tick = ext_clk & ~ext_clk_reg;
    end
  end

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  localparam logic [1:0]             LAST_ROW_RESET  = last_row(MODE_RESET.drive);
  localparam logic [PHASE_CNT_W-1:0] PHASE_LEN_RESET = phase_len(MODE_RESET.drive);
  localparam logic [NUM_BP-1:0][1:0] BP_ROW_RESET    = bp_rows(MODE_RESET.drive);

  lmt_mode_t              mode_in;
  lmt_mode_t              mode_reg;
  logic [1:0]             last_row_reg;
  logic [PHASE_CNT_W-1:0] phase_len_reg;
  logic [NUM_BP-1:0][1:0] bp_row_reg;

  // The spare bias code would leave idle pins at full swing and light each set
  // segment on every backplane, so it is folded onto third bias
  always_comb begin
    mode_in = mode_cfg;
    if (mode_cfg.bias != LMT_BIAS_STATIC && mode_cfg.bias != LMT_BIAS_HALF) begin
      mode_in.bias = LMT_BIAS_THIRD;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= MODE_RESET;
    end else if (mode_load) begin
      mode_reg <= mode_in;
    end
  end

  // Per-mode lookups are held in flops, so the tick compare and the
  // backplane match do not sit behind a divider on every cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      last_row_reg  <= LAST_ROW_RESET;
      phase_len_reg <= PHASE_LEN_RESET;
      bp_row_reg    <= BP_ROW_RESET;
    end else if (mode_load) begin
      last_row_reg  <= last_row(mode_in.drive);
      phase_len_reg <= phase_len(mode_in.drive);
      bp_row_reg    <= bp_rows(mode_in.drive);
    end
  end

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  logic [PHASE_CNT_W-1:0] phase_cnt_reg;
  logic [1:0]             phase_reg;
  logic [1:0]             row_sel_reg;
  logic                   pol_reg;
  logic                   frame_pulse_reg;
  logic                   phase_end;
  logic [1:0]             row_after_next;

  assign phase_end      = tick && (phase_cnt_reg == phase_len_reg - PHASE_CNT_W'(1));
  assign row_after_next = (row_sel_reg == last_row_reg) ? ROW_FIRST : row_sel_reg + 2'h1;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_cnt_reg <= '0;
    end else if (mode_load || phase_end) begin
      phase_cnt_reg <= '0;
    end else if (tick) begin
      phase_cnt_reg <= phase_cnt_reg + PHASE_CNT_W'(1);
    end
  end

  // Row fetch runs one phase ahead so the latch loads on the boundary
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg   <= ROW_FIRST;
      row_sel_reg <= ROW_SECOND;
    end else if (mode_load) begin
      phase_reg   <= ROW_FIRST;
      row_sel_reg <= (mode_cfg.drive == LMT_DRIVE_STATIC) ? ROW_FIRST : ROW_SECOND;
    end else if (phase_end) begin
      phase_reg   <= row_sel_reg;
      row_sel_reg <= row_after_next;
    end
  end

  // Polarity flips each time the row walk restarts, i.e. each half frame
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pol_reg <= POL_POSITIVE;
    end else if (mode_load) begin
      pol_reg <= POL_POSITIVE;
    end else if (phase_end && row_sel_reg == ROW_FIRST) begin
      pol_reg <= ~pol_reg;
    end
  end

  // The frame ends where the walk wraps back into the positive half,
  // i.e. after two half frames of twelve ticks each
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      frame_pulse_reg <= 1'h0;
    end else begin
      frame_pulse_reg <= phase_end && (row_sel_reg == ROW_FIRST) && (pol_reg != POL_POSITIVE);
    end
  end

  // ----------------------------------------------------------------
  // Display latch
  // ----------------------------------------------------------------
  // Loads only at a phase end, so the first phase after a load still
  // shows the row that was latched before it
  logic [NUM_SEG-1:0] latch_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= '0;
    end else if (phase_end) begin
      latch_reg <= ram_row_data;
    end
  end

  // ----------------------------------------------------------------
  // Level selection
  // ----------------------------------------------------------------
  lmt_level_t [NUM_BP-1:0]  bp_reg;
  lmt_level_t [NUM_SEG-1:0] seg_reg;
  lmt_level_t               bp_on_lvl;
  lmt_level_t               bp_idle_lvl;
  lmt_level_t               seg_on_lvl;
  lmt_level_t               seg_off_lvl;

  // Only two levels exist per phase on each side, so pick them once for all pins
  always_comb begin
    bp_on_lvl   = bp_level(mode_reg, 1'h1, pol_reg);
    bp_idle_lvl = bp_level(mode_reg, 1'h0, pol_reg);
    seg_on_lvl  = seg_level(mode_reg, 1'h1, pol_reg);
    seg_off_lvl = seg_level(mode_reg, 1'h0, pol_reg);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_BP; i++) bp_reg[i] <= LMT_LVL_LCD;
    end else begin
      for (int i = 0; i < NUM_BP; i++) begin
        if (!mode_reg.enable) begin
          bp_reg[i] <= LMT_LVL_LCD;
        end else begin
          bp_reg[i] <= (bp_row_reg[i] == phase_reg) ? bp_on_lvl : bp_idle_lvl;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_SEG; i++) seg_reg[i] <= LMT_LVL_LCD;
    end else begin
      for (int i = 0; i < NUM_SEG; i++) begin
        if (!mode_reg.enable) begin
          seg_reg[i] <= LMT_LVL_LCD;
        end else begin
          seg_reg[i] <= latch_reg[i] ? seg_on_lvl : seg_off_lvl;
        end
      end
    end
  end

  assign backplane_outputs = bp_reg;
  assign segment_outputs   = seg_reg;
  assign ram_row_sel       = row_sel_reg;
  assign frame_pulse       = frame_pulse_reg;
  assign mode_active       = mode_reg;

endmodule : lmt_timing

//--- testbench/lmt_ram_model.sv
// Display memory model that feeds the selected row to the core
`timescale 1ns/1ps
module lmt_ram_model
  import lmt_pkg::*;
(
  input wire logic [1:0]                      row_sel,
  input wire logic [NUM_BP-1:0][NUM_SEG-1:0]  rows,
  output logic [NUM_SEG-1:0]                  row_data
);
  assign row_data = rows[row_sel];
endmodule : lmt_ram_model

//--- testbench/lmt_timing_sva.sv
// Assertion checker for the LCD multiplex timing core
`timescale 1ns/1ps
module lmt_timing_chk
  import lmt_pkg::*;
(
  input wire logic                     mclk,
  input wire logic                     rst_n,
  input wire logic                     oscillator_source_select,
  input wire logic                     int_osc_tick,
  input wire logic                     ext_clk,
  input wire logic                     mode_load,
  input wire lmt_mode_t                mode_cfg,
  input wire lmt_level_t [NUM_BP-1:0]  backplane_outputs,
  input wire lmt_level_t [NUM_SEG-1:0] segment_outputs,
  input wire logic [1:0]               ram_row_sel,
  input wire logic                     frame_pulse,
  input wire lmt_mode_t                mode_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic ext_q_reg;
  logic quiet;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      ext_q_reg <= 1'h0;
    else
      ext_q_reg <= ext_clk;
  end
  // No tick of the selected source and no load: row select and segments may not move
  assign quiet = !mode_load && (oscillator_source_select ? !(ext_clk && !ext_q_reg) : !int_osc_tick);
  AST_RESET_STATE: assert property ($rose(rst_n) |-> mode_active == MODE_RESET)
    else $error("reset mode wrong");
  AST_MODE_LOAD: assert property (mode_load |=> mode_active == $past(mode_cfg))
    else $error("mode not loaded");
  AST_DISABLED_OFF: assert property (!mode_active.enable |=> segment_outputs == {NUM_SEG{LMT_LVL_LCD}})
    else $error("disabled display drives segments");
  AST_FROZEN_ROW: assert property (quiet |=> $stable(ram_row_sel))
    else $error("row moved without tick");
  AST_FROZEN_SEG: assert property (quiet |-> ##2 $stable(segment_outputs))
    else $error("segments moved without tick");
  AST_ROW_RANGE: assert property (ram_row_sel <= 2'(mode_active.drive))
    else $error("row beyond mode");
  AST_ROW_NEXT: assert property ($changed(ram_row_sel) && !$past(mode_load) |->
    ram_row_sel == (($past(ram_row_sel) == 2'(mode_active.drive)) ? 2'h0 : 2'($past(ram_row_sel) + 2'h1)))
    else $error("row order wrong");
  AST_STATIC_BP: assert property ($past(mode_active.drive) == LMT_DRIVE_STATIC |->
    backplane_outputs[0] == backplane_outputs[1] && backplane_outputs[2] == backplane_outputs[3]
    && backplane_outputs[0] == backplane_outputs[2])
    else $error("static backplanes differ");
  AST_MUX2_BP: assert property ($past(mode_active.drive) == LMT_DRIVE_MUX2 |->
    backplane_outputs[0] == backplane_outputs[2] && backplane_outputs[1] == backplane_outputs[3])
    else $error("paired backplanes differ");
  AST_FRAME_SINGLE: assert property (frame_pulse |=> !frame_pulse)
    else $error("frame pulse too long");
  cover property (frame_pulse && oscillator_source_select);
  cover property (frame_pulse && mode_active.drive == LMT_DRIVE_STATIC);
  cover property (frame_pulse && mode_active.bias == LMT_BIAS_HALF);
endmodule : lmt_timing_chk

bind lmt_timing lmt_timing_chk u_chk (.mclk, .rst_n, .oscillator_source_select, .int_osc_tick, .ext_clk,
  .mode_load, .mode_cfg, .backplane_outputs, .segment_outputs, .ram_row_sel, .frame_pulse, .mode_active);

//--- testbench/lmt_timing_test.sv
// Self-checking testbench for the LCD multiplex timing core
`timescale 1ns/1ps
module lmt_timing_test
  import lmt_pkg::*;
;
  typedef struct packed {
    lmt_level_t [NUM_SEG-1:0] seg;
    lmt_level_t               bp0;
    lmt_level_t               bp1;
    lmt_level_t               bp2;
    lmt_level_t               bp3;
  } lmt_note_t;
  logic                           mclk, rst_n, osc_sel, int_osc_tick, ext_clk, mode_load, frame_pulse;
  lmt_mode_t                      mode_cfg, mode_active;
  logic [NUM_BP-1:0][NUM_SEG-1:0] rows;
  logic [NUM_SEG-1:0]             ram_row_data;
  logic [1:0]                     ram_row_sel;
  lmt_level_t [NUM_BP-1:0]        bp;
  lmt_level_t [NUM_SEG-1:0]       seg;
  lmt_note_t                      notes[$];
  int                             error_cnt, compares, k;

  lmt_timing uut (.mclk, .rst_n, .oscillator_source_select(osc_sel), .int_osc_tick, .ext_clk, .mode_load,
    .mode_cfg, .ram_row_data, .backplane_outputs(bp), .segment_outputs(seg), .ram_row_sel, .frame_pulse,
    .mode_active);
  lmt_ram_model u_ram (.row_sel(ram_row_sel), .rows, .row_data(ram_row_data));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : check

  function automatic lmt_note_t expect_levels(lmt_mode_t m, logic [NUM_SEG-1:0] r);
    lmt_note_t e;
    e.bp0 = LMT_LVL_LCD;
    e.bp1 = (m.drive == LMT_DRIVE_STATIC) ? LMT_LVL_LCD : (m.bias == LMT_BIAS_THIRD) ? LMT_LVL_THIRD : LMT_LVL_HALF;
    e.bp2 = (m.drive == LMT_DRIVE_STATIC || m.drive == LMT_DRIVE_MUX2) ? e.bp0 : e.bp1;
    e.bp3 = e.bp1;
    for (int i = 0; i < NUM_SEG; i++)
      e.seg[i] = r[i] ? LMT_LVL_VSS : (m.bias == LMT_BIAS_THIRD) ? LMT_LVL_TWO_THIRDS : LMT_LVL_LCD;
    return e;
  endfunction : expect_levels

  // The unselected source runs at twice the rate, so a wrong pick shows up as a wrong frame count
  task automatic tick();
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      ext_clk      <= osc_sel ? (i < 2) : !i[0];
      int_osc_tick <= osc_sel ? !i[0] : (i == 0);
    end
    repeat ($urandom % 3 + 2) @(posedge mclk);
  endtask : tick

  task automatic load(input lmt_mode_t m);
    @(posedge mclk);
    mode_cfg  <= m;
    mode_load <= 1'b1;
    @(posedge mclk);
    mode_load <= 1'b0;
  endtask : load

  task automatic stop_test();
    $display("error_cnt %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  initial begin
    lmt_note_t e;
    forever begin
      @(posedge mclk iff frame_pulse === 1'b1);
      repeat (2) @(posedge mclk);
      #1;
      if (notes.size() == 0) begin
        check(1'b0, "unexpected frame pulse");
      end else begin
        e = notes.pop_front();
        check(seg === e.seg, "segment levels");
        check(bp[0] === e.bp0 && bp[1] === e.bp1, "backplane levels");
        check(bp[2] === e.bp2 && bp[3] === e.bp3, "upper backplane levels");
      end
    end
  end

  initial begin
    #100us;
    error_cnt++;
    stop_test();
  end

  initial begin
    rst_n        = 1'b0;
    osc_sel      = 1'b0;
    int_osc_tick = 1'b0;
    ext_clk      = 1'b0;
    mode_load    = 1'b0;
    mode_cfg     = MODE_RESET;
    rows         = '0;
    error_cnt    = 0;
    compares     = 0;
    void'($urandom(32'h1f35));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    for (int d = 0; d < 4; d++) begin
      for (int b = 1; b < 3; b++) begin
        if (d > 0 || b == 1) begin
          rows    <= {$urandom, $urandom, $urandom, $urandom};
          osc_sel <= 1'($urandom % 2);
          load('{drive: lmt_drive_t'(d), bias: lmt_bias_t'(d == 0 ? 0 : b), enable: 1'b1});
          k = 49 + $urandom % 4;
          for (int n = 1; n <= k; n++) begin
            if (n % 24 == 0) notes.push_back(expect_levels(mode_cfg, rows[0]));
            tick();
          end
        end
      end
    end
    load('{drive: LMT_DRIVE_MUX4, bias: LMT_BIAS_THIRD, enable: 1'b0});
    repeat (10) tick();
    repeat (10) @(posedge mclk);
    check(notes.size() == 0, "missing frame pulse");
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    stop_test();
  end
endmodule : lmt_timing_test
